// ---- src/vcu_pkg.sv ----
`default_nettype none
package vcu_pkg;
	localparam int unsigned VCU_CLK_HZ = 50000000;
	localparam int unsigned VCU_BAUD_DEFAULT = 115200;
	localparam int unsigned VCU_BAUD_MIN = 9600;
	localparam int unsigned VCU_BAUD_MAX = 921600;
	localparam int unsigned VCU_DIV_W = 16;
	localparam logic [VCU_DIV_W-1:0] VCU_DIV_DEFAULT = VCU_DIV_W'(VCU_CLK_HZ / VCU_BAUD_DEFAULT);
	localparam logic [VCU_DIV_W-1:0] VCU_DIV_MIN = VCU_DIV_W'(VCU_CLK_HZ / VCU_BAUD_MAX);
	localparam logic [VCU_DIV_W-1:0] VCU_DIV_MAX = VCU_DIV_W'(VCU_CLK_HZ / VCU_BAUD_MIN);
	localparam int unsigned VCU_DATA_W = 8;
	localparam int unsigned VCU_FIFO_DEPTH = 4;
	localparam logic [3:0] VCU_FRAME_BITS = 4'hA;
	localparam logic [1:0] VCU_HS_DEFAULT = 2'h0;
	typedef enum logic [1:0] {
		VCU_HS_DISABLED = 2'b00,
		VCU_HS_RTS = 2'b01,
		VCU_HS_CTS = 2'b10,
		VCU_HS_RTSCTS = 2'b11
	} vcu_hs_t;
	typedef enum logic [1:0] {
		VCU_ST_IDLE = 2'b00,
		VCU_ST_START = 2'b01,
		VCU_ST_DATA = 2'b10,
		VCU_ST_STOP = 2'b11
	} vcu_state_t;
endpackage
`default_nettype wire

// ---- src/vcu_fifo.sv ----
`default_nettype none
module vcu_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;
	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = mem_q[rp_q];
	always_comb begin
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		wp_d = push ? AW'((wp_q + 1'b1) % DEPTH) : wp_q;
		rp_d = pop ? AW'((rp_q + 1'b1) % DEPTH) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (i_ce) begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			if (push) begin
				mem_q[wp_q] <= i_in_data;
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/vcu_bridge.sv ----
`default_nettype none
module vcu_bridge
	import vcu_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_enable,
	input wire logic [1:0] i_hs_mode,
	input wire logic [VCU_DIV_W-1:0] i_baud_div,
	input wire logic i_cfg_load,
	input wire logic i_rx_line,
	output logic o_tx_line,
	output logic o_host_rdy_o,
	output logic o_host_rdy_oe_n,
	input wire logic i_tgt_rdy,
	input wire logic i_h2t_valid,
	output logic o_h2t_ready,
	input wire logic [VCU_DATA_W-1:0] i_h2t_data,
	output logic o_t2h_valid,
	input wire logic i_t2h_ready,
	output logic [VCU_DATA_W-1:0] o_t2h_data,
	output logic o_t2h_frame_err,
	output logic o_tx_busy
);
	function automatic logic [VCU_DIV_W-1:0] clamp_div(input logic [VCU_DIV_W-1:0] d);
		if (d < VCU_DIV_MIN) begin
			return VCU_DIV_MIN;
		end else if (d > VCU_DIV_MAX) begin
			return VCU_DIV_MAX;
		end
		return d;
	endfunction

	function automatic logic [VCU_DIV_W-1:0] dec_div(input logic [VCU_DIV_W-1:0] v);
		return v - VCU_DIV_W'(1);
	endfunction

	// Configuration registers.
	logic [1:0] hs_q, hs_d;
	logic [VCU_DIV_W-1:0] div_q, div_d;
	logic gate_en, thr_en;
	always_comb begin
		hs_d = hs_q;
		div_d = div_q;
		if (i_cfg_load) begin
			hs_d = i_hs_mode;
			div_d = clamp_div(i_baud_div);
		end
		gate_en = hs_q[1];
		thr_en = hs_q[0];
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			hs_q <= VCU_HS_DEFAULT;
			div_q <= VCU_DIV_DEFAULT;
		end else if (i_ce) begin
			hs_q <= hs_d;
			div_q <= div_d;
		end
	end

	// Pin synchronisers.
	logic rx_m_q, rx_s_q, cts_m_q, cts_s_q;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
			cts_m_q <= 1'b0;
			cts_s_q <= 1'b0;
		end else if (i_ce) begin
			rx_m_q <= i_rx_line;
			rx_s_q <= rx_m_q;
			cts_m_q <= i_tgt_rdy;
			cts_s_q <= cts_m_q;
		end
	end

	// Transmitter toward the target.
	vcu_state_t tst_q, tst_d;
	logic [VCU_DIV_W-1:0] tcnt_q, tcnt_d;
	logic [2:0] tbit_q, tbit_d;
	logic [VCU_DATA_W-1:0] tsh_q, tsh_d;
	logic tx_q, tx_d;
	logic h2t_take, busy_q, busy_d;
	always_comb begin
		tst_d = tst_q;
		tcnt_d = tcnt_q;
		tbit_d = tbit_q;
		tsh_d = tsh_q;
		tx_d = tx_q;
		h2t_take = 1'b0;
		case (tst_q)
			VCU_ST_IDLE: begin
				tx_d = 1'b1;
				// Target-ready only looked at here, never mid-byte.
				if (i_enable && i_h2t_valid && (!gate_en || cts_s_q)) begin
					h2t_take = 1'b1;
					tsh_d = i_h2t_data;
					tcnt_d = dec_div(div_q);
					tx_d = 1'b0;
					tst_d = VCU_ST_START;
				end
			end
			VCU_ST_START, VCU_ST_DATA, VCU_ST_STOP: begin
				// A running byte ignores target-ready and enable.
				if (tcnt_q != '0) begin
					tcnt_d = dec_div(tcnt_q);
				end else begin
					tcnt_d = dec_div(div_q);
					case (tst_q)
						VCU_ST_START: begin
							tx_d = tsh_q[0];
							tsh_d = tsh_q >> 1;
							tbit_d = 3'h0;
							tst_d = VCU_ST_DATA;
						end
						VCU_ST_DATA: begin
							if (tbit_q == 3'h7) begin
								tx_d = 1'b1;
								tst_d = VCU_ST_STOP;
							end else begin
								tx_d = tsh_q[0];
								tsh_d = tsh_q >> 1;
								tbit_d = tbit_q + 3'h1;
							end
						end
						default: begin
							tst_d = VCU_ST_IDLE;
						end
					endcase
				end
			end
			default: tst_d = VCU_ST_IDLE;
		endcase
		busy_d = (tst_d != VCU_ST_IDLE);
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			busy_q <= 1'b0;
			tst_q <= VCU_ST_IDLE;
			tcnt_q <= '0;
			tbit_q <= '0;
			tsh_q <= '0;
			tx_q <= 1'b1;
		end else if (i_ce) begin
			tst_q <= tst_d;
			tcnt_q <= tcnt_d;
			tbit_q <= tbit_d;
			tsh_q <= tsh_d;
			tx_q <= tx_d;
			busy_q <= busy_d;
		end
	end

	// Receiver from the target.
	vcu_state_t rst_q, rst_d;
	logic [VCU_DIV_W-1:0] rcnt_q, rcnt_d;
	logic [2:0] rbit_q, rbit_d;
	logic [VCU_DATA_W-1:0] rsh_q, rsh_d;
	logic rpush, fifo_in_rdy, ferr_q, ferr_d;
	always_comb begin
		rst_d = rst_q;
		rcnt_d = rcnt_q;
		rbit_d = rbit_q;
		rsh_d = rsh_q;
		rpush = 1'b0;
		ferr_d = ferr_q;
		case (rst_q)
			VCU_ST_IDLE: begin
				if (i_enable && !rx_s_q) begin
					rcnt_d = div_q >> 1;
					rst_d = VCU_ST_START;
				end
			end
			VCU_ST_START, VCU_ST_DATA, VCU_ST_STOP: begin
				if (rcnt_q != '0) begin
					rcnt_d = dec_div(rcnt_q);
				end else begin
					rcnt_d = dec_div(div_q);
					case (rst_q)
						VCU_ST_START: begin
							// A glitch shorter than half a bit is not a start.
							rst_d = rx_s_q ? VCU_ST_IDLE : VCU_ST_DATA;
							rbit_d = 3'h0;
						end
						VCU_ST_DATA: begin
							rsh_d = {rx_s_q, rsh_q[VCU_DATA_W-1:1]};
							rbit_d = rbit_q + 3'h1;
							if (rbit_q == 3'h7) begin
								rst_d = VCU_ST_STOP;
							end
						end
						default: begin
							// A byte arriving into a full buffer is dropped.
							rpush = rx_s_q && fifo_in_rdy;
							ferr_d = !rx_s_q;
							rst_d = VCU_ST_IDLE;
						end
					endcase
				end
			end
			default: rst_d = VCU_ST_IDLE;
		endcase
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rst_q <= VCU_ST_IDLE;
			rcnt_q <= '0;
			rbit_q <= '0;
			rsh_q <= '0;
			ferr_q <= 1'b0;
		end else if (i_ce) begin
			rst_q <= rst_d;
			rcnt_q <= rcnt_d;
			rbit_q <= rbit_d;
			rsh_q <= rsh_d;
			ferr_q <= ferr_d;
		end
	end

	logic fifo_out_valid;
	logic [VCU_DATA_W-1:0] fifo_out_data;
	logic t2h_valid_q, t2h_valid_d;
	logic [VCU_DATA_W-1:0] t2h_data_q, t2h_data_d;
	logic fifo_pop;
	vcu_fifo #(
		.WIDTH(VCU_DATA_W),
		.DEPTH(VCU_FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_in_valid(rpush),
		.o_in_ready(fifo_in_rdy),
		.i_in_data(rsh_q),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_out_data)
	);

	// Output stage registered so host-facing outputs come from flops.
	logic rdy_q, rdy_d, oe_n_q, oe_n_d, h2t_rdy_q, h2t_rdy_d;
	logic [2:0] occ_q, occ_d;
	always_comb begin
		fifo_pop = !t2h_valid_q || i_t2h_ready;
		t2h_valid_d = t2h_valid_q;
		t2h_data_d = t2h_data_q;
		if (fifo_pop) begin
			t2h_valid_d = fifo_out_valid;
			t2h_data_d = fifo_out_data;
		end
		occ_d = occ_q + 3'(rpush) - 3'(fifo_pop && fifo_out_valid);
		// Built from the next occupancy, so the line falls on the edge the last slot fills.
		rdy_d = (occ_d != 3'(VCU_FIFO_DEPTH));
		oe_n_d = !thr_en;
		h2t_rdy_d = h2t_take;
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			t2h_valid_q <= 1'b0;
			t2h_data_q <= '0;
			rdy_q <= 1'b0;
			occ_q <= '0;
			oe_n_q <= 1'b1;
			h2t_rdy_q <= 1'b0;
		end else if (i_ce) begin
			t2h_valid_q <= t2h_valid_d;
			t2h_data_q <= t2h_data_d;
			rdy_q <= rdy_d;
			occ_q <= occ_d;
			oe_n_q <= oe_n_d;
			h2t_rdy_q <= h2t_rdy_d;
		end
	end

	assign o_tx_line = tx_q;
	assign o_host_rdy_o = rdy_q;
	assign o_host_rdy_oe_n = oe_n_q;
	assign o_h2t_ready = h2t_rdy_q;
	assign o_t2h_valid = t2h_valid_q;
	assign o_t2h_data = t2h_data_q;
	assign o_t2h_frame_err = ferr_q;
	assign o_tx_busy = busy_q;
endmodule
`default_nettype wire

// ---- tb/vcu_tgt_model.sv ----
`default_nettype none
module vcu_tgt_model (
	input wire logic i_sys_clk,
	input wire logic i_line,
	input wire logic i_host_rdy,
	input wire logic i_honor,
	input wire logic [15:0] i_div,
	output logic o_line,
	output logic [7:0] o_byte,
	output int o_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// The receiver never refuses, so a byte already in flight always finds room.
	initial begin
		o_line = 1'b1;
		o_cnt = 0;
		forever begin
			@(negedge i_line);
			repeat (i_div / 2) @(posedge i_sys_clk);
			for (int b = 0; b < 9; b++) begin
				repeat (i_div) @(posedge i_sys_clk);
				if (b < 8) o_byte[b] = i_line;
			end
			if (i_line) o_cnt++;
		end
	end
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		while (i_honor && !i_host_rdy) @(posedge i_sys_clk);
		for (int b = 0; b < 10; b++) begin
			o_line <= f[b];
			repeat (i_div) @(posedge i_sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/vcu_bridge_asserts.sv ----
`default_nettype none
module vcu_bridge_chk
	import vcu_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic [1:0] i_hs_mode,
	input wire logic [VCU_DIV_W-1:0] i_baud_div,
	input wire logic i_cfg_load,
	input wire logic i_tgt_rdy,
	input wire logic i_h2t_valid,
	input wire logic o_tx_line,
	input wire logic o_host_rdy_o,
	input wire logic o_host_rdy_oe_n,
	input wire logic o_h2t_ready,
	input wire logic o_t2h_valid,
	input wire logic o_tx_busy
);
	// Shadow of the loaded settings; the bench loads only in-range dividers.
	logic [1:0] mode_q;
	logic [VCU_DIV_W-1:0] div_q;
	logic [15:0] busy_q;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			mode_q <= VCU_HS_DEFAULT;
			div_q <= VCU_DIV_DEFAULT;
		end else if (i_cfg_load) begin
			mode_q <= i_hs_mode;
			div_q <= i_baud_div;
		end
		busy_q <= o_tx_busy ? busy_q + 16'h1 : 16'h0;
	end
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	a_drive_mode: assert property ($stable(mode_q) |-> o_host_rdy_oe_n == !mode_q[0])
		else $error("drive mode");
	a_idle_high: assert property (!o_tx_busy |-> o_tx_line)
		else $error("idle level");
	a_start_low: assert property ($rose(o_h2t_ready) |-> (!o_tx_line) [*8])
		else $error("start bit");
	a_gate_stall: assert property ((mode_q[1] && !i_tgt_rdy) [*5] |=> !o_h2t_ready)
		else $error("gate stall");
	a_gate_off: assert property (
		!mode_q[1] && i_enable && i_h2t_valid && !o_tx_busy && !o_h2t_ready |-> ##[0:4] o_h2t_ready)
		else $error("gate off");
	a_en_gate: assert property ((!i_enable) [*2] |=> !o_h2t_ready)
		else $error("enable gate");
	a_frame_len: assert property ($fell(o_tx_busy) |->
		busy_q + 16'h3 >= 16'(16'hA * div_q) && busy_q <= 16'(16'hA * div_q) + 16'h3)
		else $error("frame length");
	a_full_hold: assert property (!o_host_rdy_oe_n && !o_host_rdy_o |-> o_t2h_valid)
		else $error("throttle empty");
	c_gate_wait: cover property (mode_q[1] && !i_tgt_rdy && i_h2t_valid);
	c_throttle: cover property (!o_host_rdy_oe_n && !o_host_rdy_o);
	c_mid_drop: cover property (o_tx_busy && $fell(i_tgt_rdy));
endmodule
bind vcu_bridge vcu_bridge_chk u_chk (.i_sys_clk, .i_rst_n, .i_enable, .i_hs_mode, .i_baud_div,
	.i_cfg_load, .i_tgt_rdy, .i_h2t_valid, .o_tx_line, .o_host_rdy_o, .o_host_rdy_oe_n,
	.o_h2t_ready, .o_t2h_valid, .o_tx_busy);
`default_nettype wire

// ---- tb/tb_vcu_uart_flow_control.sv ----
`default_nettype none
module tb_vcu_uart_flow_control import vcu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk, i_rst_n, i_enable, i_cfg_load, i_tgt_rdy, i_h2t_valid, i_t2h_ready, honor;
	logic i_rx_line, o_tx_line, o_host_rdy_o, o_host_rdy_oe_n, o_h2t_ready, o_t2h_valid, o_tx_busy;
	logic t2h_ferr;
	logic [1:0] i_hs_mode;
	logic [VCU_DIV_W-1:0] i_baud_div;
	logic [7:0] i_h2t_data, o_t2h_data, rx_byte;
	int rx_cnt, n_mismatch = 0, samples_checked = 0, cyc = 0;
	vcu_bridge dut_u (.i_sys_clk, .i_rst_n, .i_ce(1'b1), .i_enable, .i_hs_mode, .i_baud_div,
		.i_cfg_load, .i_rx_line, .o_tx_line, .o_host_rdy_o, .o_host_rdy_oe_n, .i_tgt_rdy,
		.i_h2t_valid, .o_h2t_ready, .i_h2t_data, .o_t2h_valid, .i_t2h_ready, .o_t2h_data,
		.o_t2h_frame_err(t2h_ferr), .o_tx_busy);
	vcu_tgt_model tgt_u (.i_sys_clk, .i_line(o_tx_line), .i_host_rdy(o_host_rdy_o),
		.i_honor(honor), .i_div(i_baud_div), .o_line(i_rx_line), .o_byte(rx_byte), .o_cnt(rx_cnt));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_sim;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Loads wait for an idle line; a divider change mid-frame would stretch only part of it.
	task automatic cfg(input logic [1:0] m);
		while (o_tx_busy) @(posedge i_sys_clk);
		@(posedge i_sys_clk);
		i_hs_mode <= m;
		i_baud_div <= VCU_DIV_MIN;
		i_cfg_load <= 1'b1;
		@(posedge i_sys_clk);
		i_cfg_load <= 1'b0;
	endtask
	// Valid drops on the acknowledge edge, since holding it longer could start a second byte.
	task automatic put(input logic [7:0] d, input int n);
		@(posedge i_sys_clk);
		i_h2t_valid <= 1'b1;
		i_h2t_data <= d;
		do @(posedge i_sys_clk); while (o_h2t_ready !== 1'b1);
		i_h2t_valid <= 1'b0;
		wait (rx_cnt == n);
		chk("to target", d, rx_byte);
	endtask
	task automatic t_dflt;
		chk("drive off", 8'h01, {7'h0, o_host_rdy_oe_n});
		put(8'hA5, 1);
	endtask
	task automatic t_gate;
		cfg(VCU_HS_CTS);
		fork
			put(8'hC3, 2);
			begin
				repeat (800) @(posedge i_sys_clk);
				chk("gated", 8'h01, rx_cnt[7:0]);
				i_tgt_rdy <= 1'b1;
			end
		join
		chk("drive off", 8'h01, {7'h0, o_host_rdy_oe_n});
		cfg(VCU_HS_RTSCTS);
		fork
			put(8'h5A, 3);
			begin
				@(posedge i_sys_clk iff o_h2t_ready);
				i_tgt_rdy <= 1'b0;
			end
		join
		i_tgt_rdy <= 1'b1;
	endtask
	task automatic t_rts;
		cfg(VCU_HS_RTS);
		honor <= 1'b1;
		fork
			for (int k = 1; k < 7; k++) tgt_u.send(8'(8'h11 * k));
			begin
				repeat (3000) @(posedge i_sys_clk);
				chk("host ready", 8'h00, {7'h0, o_host_rdy_o});
				chk("drive on", 8'h00, {7'h0, o_host_rdy_oe_n});
				i_t2h_ready <= 1'b1;
				for (int k = 1; k < 7; k++) begin
					do @(posedge i_sys_clk); while (o_t2h_valid !== 1'b1);
					chk("to host", 8'(8'h11 * k), o_t2h_data);
				end
				chk("frame error", 8'h00, {7'h0, t2h_ferr});
				i_t2h_ready <= 1'b0;
			end
		join
		honor <= 1'b0;
	endtask
	task automatic t_en;
		i_enable <= 1'b0;
		i_tgt_rdy <= 1'b0;
		fork
			put(8'h96, 4);
			begin
				repeat (800) @(posedge i_sys_clk);
				chk("disabled", 8'h03, rx_cnt[7:0]);
				i_enable <= 1'b1;
			end
		join
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		{i_rst_n, i_cfg_load, i_tgt_rdy, i_h2t_valid, i_t2h_ready, honor} = '0;
		i_enable = 1'b1;
		i_hs_mode = VCU_HS_DISABLED;
		i_baud_div = VCU_DIV_DEFAULT;
		i_h2t_data = 8'h00;
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_dflt();
		t_gate();
		t_rts();
		t_en();
		end_sim();
	end
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			end_sim();
		end
	end
endmodule
`default_nettype wire
